// *** dv/oscfg_motor_model.sv ***
// Purpose: Motor driver side model with travel limit switches
// Assumes: One step per cycle while step_i is high
// Notes:   Limit switches close at the travel ends, active high
`timescale 1ns/1ps
module oscfg_motor_model #(
    parameter int TRAVEL = 4
) (
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic [1:0] step_i,
    input  wire logic [1:0] dir_ccw_i,
    output logic      [1:0] lim_cw_o,
    output logic      [1:0] lim_ccw_o
);
    int pos_r [2];
    // Position count per axis
    always_ff @(posedge clk_i) begin
        for (int k = 0; k < 2; k++) begin
            if (srst_i) begin
                pos_r[k] <= 0;
            end else if (step_i[k]) begin
                pos_r[k] <= dir_ccw_i[k] ? pos_r[k] - 1 : pos_r[k] + 1;
            end
        end
    end
    // Switches at both ends of travel
    always_comb begin
        for (int k = 0; k < 2; k++) begin
            lim_cw_o[k]  = (pos_r[k] >= TRAVEL);
            lim_ccw_o[k] = (pos_r[k] <= -TRAVEL);
        end
    end
endmodule

// *** dv/tb_top.sv ***
// Purpose: Self-checking bench for the origin-search setup block
// Assumes: APB answers after one wait state, pulses act on the next edge
// Notes:   Clock enable drops once to show that a start pulse is ignored
`timescale 1ns/1ps
module tb_top;
    import oscfg_pkg::*;
    localparam int TRAVEL = 4;
    logic        clk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1;
    logic [11:0] paddr_i = 12'h000;
    logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [31:0] pwdata_i = 32'h0, prdata_o;
    logic [3:0]  pstrb_i = 4'hF;
    logic        power_up_i = 1'b0, op_start_i = 1'b0, search_busy_i = 1'b0;
    logic        pwm0_i = 1'b1, dir1 = 1'b0;
    logic [1:0]  irq_req_i = 2'h3, irq_req_o, lim_cw_i, lim_ccw_i, step = 2'h0;
    logic        pready_o, pslverr_o, search_en_o, limit_always_o, s_curve_o;
    logic        reverse2_o, ccw_dir_o, cfg_err_o, limit_active_o, pwm0_o;
    logic        irq0_avail_o, irq1_avail_o, pwm0_avail_o, hsc0_avail_o, hsc1_avail_o;
    logic        out0_cw_limit_flag_o, out0_ccw_limit_flag_o;
    logic        out1_cw_limit_flag_o, out1_ccw_limit_flag_o;
    oscfg_mode_e mode_o;
    oscfg_det_e  detect_o;
    int          errors = 0, compares = 0, cyc = 0;

    // Clock and hang guard
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            errors++;
            stop_test();
        end
    end

    oscfg_top oscfg_top_inst (
        .clk_i, .srst_i, .ce_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i,
        .pstrb_i, .pready_o, .prdata_o, .pslverr_o, .power_up_i, .op_start_i,
        .search_busy_i, .lim_cw_i, .lim_ccw_i, .irq_req_i, .pwm0_i, .search_en_o,
        .limit_always_o, .s_curve_o, .mode_o, .reverse2_o, .detect_o, .ccw_dir_o,
        .cfg_err_o, .limit_active_o, .irq_req_o, .pwm0_o, .irq0_avail_o, .irq1_avail_o,
        .pwm0_avail_o, .hsc0_avail_o, .hsc1_avail_o, .out0_cw_limit_flag_o,
        .out0_ccw_limit_flag_o, .out1_cw_limit_flag_o, .out1_ccw_limit_flag_o
    );
    oscfg_motor_model #(.TRAVEL(TRAVEL)) oscfg_motor_model_inst (
        .clk_i, .srst_i, .step_i(step), .dir_ccw_i({dir1, ccw_dir_o}),
        .lim_cw_o(lim_cw_i), .lim_ccw_o(lim_ccw_i)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic reset();
        srst_i <= 1'b1;
        tick(4);
        srst_i <= 1'b0;
    endtask
    // One APB transfer, held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i <= 1'b1;
        paddr_i <= a;
        pwrite_i <= wr;
        pwdata_i <= d;
        pstrb_i <= s;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        rd = prdata_o;
        err = pslverr_o;
        chk("pready_o", pready_o, 1'b1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, {16'h0, d}, s, rd, err);
    endtask
    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0, 4'hF, rd, err);
        chk(name, rd, exp);
    endtask
    task automatic pulse(input bit start);
        if (start) op_start_i <= 1'b1;
        else power_up_i <= 1'b1;
        @(posedge clk_i);
        op_start_i <= 1'b0;
        power_up_i <= 1'b0;
        tick(2);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] rd;
        logic        err;
        rd_chk("word0 reset", OSC_ADDR_W0, 32'h0);
        rd_chk("word1 reset", OSC_ADDR_W1, 32'h0);
        apb(1'b0, 12'h7F0, 32'h0, 4'hF, rd, err);
        chk("unmapped err", err, 1'b1);
        chk("unmapped data", rd, 32'h0);
        $display("Done t_reset");
    endtask
    task automatic t_power_on();
        logic [15:0] tbl [5] = '{16'h0000, 16'h0002, 16'h1F11, 16'h0010, 16'h0001};
        logic [15:0] w;
        logic        en;
        for (int i = 0; i < 5; i++) begin
            w = tbl[i];
            en = (w[3:0] == 4'h1);
            reset();
            wr(OSC_ADDR_W0, w, 4'hF);
            chk("search_en_o early", search_en_o, 1'b0);
            pulse(0);
            chk("search_en_o", search_en_o, en);
            chk("limit_always_o", limit_always_o, w[7:4] == 4'h1);
            chk("s_curve_o", s_curve_o, w[15:12] == 4'h1);
            chk("cfg_err_o", cfg_err_o, w[3:0] > 1 || w[7:4] > 1 || w[15:12] > 1);
            chk("irq_req_o", irq_req_o, en ? 2'h0 : 2'h3);
            chk("pwm0_o", pwm0_o, !en);
            chk("avail", {irq0_avail_o, irq1_avail_o, pwm0_avail_o}, en ? 3'h0 : 3'h7);
            chk("hsc avail", {hsc0_avail_o, hsc1_avail_o}, 2'h3);
            chk("limit_active_o", limit_active_o, w[7:4] == 4'h1);
            search_busy_i <= 1'b1;
            tick(1);
            chk("limit_active_o busy", limit_active_o, 1'b1);
            search_busy_i <= 1'b0;
            wr(OSC_ADDR_W0, ~w, 4'hF);
            pulse(0);
            chk("search_en_o held", search_en_o, en);
            chk("s_curve_o held", s_curve_o, w[15:12] == 4'h1);
        end
        $display("Done t_power_on");
    endtask
    task automatic t_start();
        logic [15:0] bad [4] = '{16'h0003, 16'h0020, 16'h0300, 16'h2000};
        logic [15:0] w;
        for (int i = 0; i < 36; i++) begin
            w = {4'(i / 18), 4'(i / 6 % 3), 4'(i / 3 % 2), 4'(i % 3)};
            wr(OSC_ADDR_W1, w, 4'hF);
            pulse(1);
            chk("mode_o", mode_o, w[3:0]);
            chk("reverse2_o", reverse2_o, w[4]);
            chk("detect_o", detect_o, w[11:8]);
            chk("ccw_dir_o", ccw_dir_o, w[12]);
            chk("cfg_err_o", cfg_err_o, 1'b0);
            wr(OSC_ADDR_W1, w ^ 16'h1011, 4'hF);
            tick(2);
            chk("held", {ccw_dir_o, reverse2_o, mode_o}, {w[12], w[4], w[1:0]});
        end
        for (int i = 0; i < 4; i++) begin
            wr(OSC_ADDR_W1, bad[i], 4'hF);
            pulse(1);
            chk("bad decode", {mode_o, reverse2_o, detect_o, ccw_dir_o}, 6'h0);
            chk("bad err", cfg_err_o, 1'b1);
        end
        wr(OSC_ADDR_W1, 16'h1111, 4'hF);
        wr(OSC_ADDR_W1, 16'h2222, 4'h1);
        rd_chk("word1 lanes", OSC_ADDR_W1, 32'h1122);
        wr(OSC_ADDR_W1, 16'h0011, 4'hF);
        pulse(1);
        chk("err renewed", cfg_err_o, 1'b0);
        wr(OSC_ADDR_W1, 16'h1000, 4'hF);
        ce_i <= 1'b0;
        pulse(1);
        ce_i <= 1'b1;
        chk("ce freeze", ccw_dir_o, 1'b0);
        $display("Done t_start");
    endtask
    task automatic t_limits();
        dir1 <= 1'b1;
        step <= 2'h3;
        tick(TRAVEL);
        step <= 2'h0;
        tick(2);
        chk("flags", {out1_ccw_limit_flag_o, out1_cw_limit_flag_o,
                      out0_ccw_limit_flag_o, out0_cw_limit_flag_o}, 4'h9);
        rd_chk("status", OSC_ADDR_STAT, 32'h0009_4051);
        pulse(1);
        dir1 <= 1'b0;
        step <= 2'h3;
        tick(2 * TRAVEL);
        step <= 2'h0;
        tick(2);
        chk("flags back", {out1_ccw_limit_flag_o, out1_cw_limit_flag_o,
                           out0_ccw_limit_flag_o, out0_cw_limit_flag_o}, 4'h6);
        $display("Done t_limits");
    endtask

    // Verdict and end of run
    task automatic stop_test();
        $display("Counts: %0d compares, %0d errors", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        reset();
        t_reset();
        t_power_on();
        t_start();
        t_limits();
        stop_test();
    end
endmodule

// *** hdl/oscfg_pkg.sv ***
// Purpose: Constants and types for the origin-search setup block
// Assumes: APB byte addresses are four times the word index
// Notes:   Setup fields are four bits wide, codes in the low bits
package oscfg_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [11:0] OSC_IDX_W0    = 12'h100;  // Enable and profile word
    localparam logic [11:0] OSC_IDX_W1    = 12'h101;  // Search method word
    localparam logic [11:0] OSC_IDX_STAT  = 12'h102;  // Latched view and flags
    localparam logic [11:0] OSC_ADDR_W0   = {OSC_IDX_W0[9:0], 2'b00};
    localparam logic [11:0] OSC_ADDR_W1   = {OSC_IDX_W1[9:0], 2'b00};
    localparam logic [11:0] OSC_ADDR_STAT = {OSC_IDX_STAT[9:0], 2'b00};
    localparam logic [15:0] OSC_W0_RST    = 16'h0000;
    localparam logic [15:0] OSC_W1_RST    = 16'h0000;

    // ----------------------------------------------------------------
    // Field positions and legal code limits
    // ----------------------------------------------------------------
    localparam int unsigned OSC_EN_LSB    = 0;
    localparam int unsigned OSC_SCOPE_LSB = 4;
    localparam int unsigned OSC_CURVE_LSB = 12;
    localparam int unsigned OSC_MODE_LSB  = 0;
    localparam int unsigned OSC_REV_LSB   = 4;
    localparam int unsigned OSC_DET_LSB   = 8;
    localparam int unsigned OSC_DIR_LSB   = 12;
    localparam logic [3:0]  OSC_MAX_BIN   = 4'h1;     // Two-way fields
    localparam logic [3:0]  OSC_MAX_TRI   = 4'h2;     // Mode and detect fields

    // ----------------------------------------------------------------
    // Status word bit positions
    // ----------------------------------------------------------------
    localparam int unsigned OSC_ST_EN     = 0;
    localparam int unsigned OSC_ST_SCOPE  = 1;
    localparam int unsigned OSC_ST_CURVE  = 2;
    localparam int unsigned OSC_ST_MODE   = 4;
    localparam int unsigned OSC_ST_REV    = 6;
    localparam int unsigned OSC_ST_DET    = 8;
    localparam int unsigned OSC_ST_DIR    = 10;
    localparam int unsigned OSC_ST_PERR   = 12;
    localparam int unsigned OSC_ST_SERR   = 13;
    localparam int unsigned OSC_ST_PWRUP  = 14;
    localparam int unsigned OSC_ST_LIM    = 16;

    // ----------------------------------------------------------------
    // Decoded setting types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        OSCFG_MODE0 = 2'b00,
        OSCFG_MODE1 = 2'b01,
        OSCFG_MODE2 = 2'b10
    } oscfg_mode_e;

    typedef enum logic [1:0] {
        OSCFG_DET0 = 2'b00,
        OSCFG_DET1 = 2'b01,
        OSCFG_DET2 = 2'b10
    } oscfg_det_e;

    // Four-bit field taken from a setup word
    function automatic logic [3:0] oscfg_fld(input logic [15:0] w, input int unsigned lsb);
        oscfg_fld = w[lsb +: 4];
    endfunction

    // Field holds a listed code
    function automatic logic oscfg_ok(input logic [3:0] f, input logic [3:0] mx);
        oscfg_ok = (f <= mx);
    endfunction

endpackage

// *** hdl/oscfg_setup_regs.sv ***
// Purpose: Storage for the two setup words with a registered read port
// Assumes: One write and one read per cycle, both synchronous
// Notes:   Word outputs come straight from the storage flops
`timescale 1ns/1ps
module oscfg_setup_regs
    import oscfg_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        ce_i,
    input  wire logic        we_i,
    input  wire logic        waddr_i,
    input  wire logic [1:0]  wstrb_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        re_i,
    input  wire logic        raddr_i,
    output logic      [15:0] rdata_o,
    output logic      [15:0] word0_o,
    output logic      [15:0] word1_o
);

    logic [15:0] mem_r [0:1];

    // --------------------------------------------------------------
    // Byte-lane writes
    // --------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mem_r[0] <= OSC_W0_RST;
            mem_r[1] <= OSC_W1_RST;
        end else if (ce_i && we_i) begin
            if (wstrb_i[0]) mem_r[waddr_i][7:0]  <= wdata_i[7:0];
            if (wstrb_i[1]) mem_r[waddr_i][15:8] <= wdata_i[15:8];
        end
    end

    // Registered read port
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o <= 16'h0000;
        end else if (ce_i && re_i) begin
            rdata_o <= mem_r[raddr_i];
        end
    end

    assign word0_o = mem_r[0];
    assign word1_o = mem_r[1];

endmodule

// *** hdl/oscfg_top.sv ***
// Purpose: Origin-search setup for pulse output 0, APB slave
// Assumes: Inputs synchronous to clk_i; power_up_i pulses once at boot
// Notes:   Bad codes decode as code 0 and raise a setup error flag
`timescale 1ns/1ps

module oscfg_top #(
    parameter bit VER2_UNIT = 1'b1
) (
    input  wire logic                  clk_i,
    input  wire logic                  srst_i,
    input  wire logic                  ce_i,
    input  wire logic [11:0]           paddr_i,
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [31:0]           pwdata_i,
    input  wire logic [3:0]            pstrb_i,
    output logic                       pready_o,
    output logic      [31:0]           prdata_o,
    output logic                       pslverr_o,
    input  wire logic                  power_up_i,
    input  wire logic                  op_start_i,
    input  wire logic                  search_busy_i,
    input  wire logic [1:0]            lim_cw_i,
    input  wire logic [1:0]            lim_ccw_i,
    input  wire logic [1:0]            irq_req_i,
    input  wire logic                  pwm0_i,
    output logic                       search_en_o,
    output logic                       limit_always_o,
    output logic                       s_curve_o,
    output oscfg_pkg::oscfg_mode_e     mode_o,
    output logic                       reverse2_o,
    output oscfg_pkg::oscfg_det_e      detect_o,
    output logic                       ccw_dir_o,
    output logic                       cfg_err_o,
    output logic                       limit_active_o,
    output logic      [1:0]            irq_req_o,
    output logic                       pwm0_o,
    output logic                       irq0_avail_o,
    output logic                       irq1_avail_o,
    output logic                       pwm0_avail_o,
    output logic                       hsc0_avail_o,
    output logic                       hsc1_avail_o,
    output logic                       out0_cw_limit_flag_o,
    output logic                       out0_ccw_limit_flag_o,
    output logic                       out1_cw_limit_flag_o,
    output logic                       out1_ccw_limit_flag_o
);
    import oscfg_pkg::*;

    // --------------------------------------------------------------
    // Declarations
    // --------------------------------------------------------------
    logic        hit_w0;
    logic        hit_w1;
    logic        hit_st;
    logic        setup_ph;
    logic        acc_ph;
    logic        ack_r;
    logic        err_nxt;
    logic        sel_mem_r;
    logic [15:0] mem_q;
    logic [15:0] word0;
    logic [15:0] word1;
    logic [31:0] stat;
    logic        pwrup_done_r;
    logic        take_pwr;
    logic        take_run;
    logic [3:0]  f_en;
    logic [3:0]  f_scope;
    logic [3:0]  f_curve;
    logic [3:0]  f_mode;
    logic [3:0]  f_rev;
    logic [3:0]  f_det;
    logic [3:0]  f_dir;
    logic        pwr_bad;
    logic        run_bad;
    logic        perr_r;
    logic        serr_r;
    logic [3:0]  lim_r;

    // --------------------------------------------------------------
    // APB decode
    // --------------------------------------------------------------
    assign setup_ph = psel_i && !penable_i;
    assign acc_ph   = psel_i && penable_i;

    // Address match on whole word addresses
    always_comb begin
        hit_w0 = 1'b0;
        hit_w1 = 1'b0;
        hit_st = 1'b0;
        if (paddr_i == OSC_ADDR_W0) begin
            hit_w0 = 1'b1;
        end else if (paddr_i == OSC_ADDR_W1) begin
            hit_w1 = 1'b1;
        end else if (paddr_i == OSC_ADDR_STAT) begin
            hit_st = 1'b1;
        end
    end

    assign err_nxt = !(hit_w0 || hit_w1 || hit_st);

    // One wait state, answer on second access cycle
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ack_r <= 1'b0;
        end else if (ce_i) begin
            ack_r <= acc_ph && !ack_r;
        end
    end

    assign pready_o  = ce_i && acc_ph && ack_r;  // No answer while frozen
    assign pslverr_o = pready_o && err_nxt;

    // Read data captured in first access cycle
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sel_mem_r <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else if (ce_i) begin
            if (setup_ph) begin
                sel_mem_r <= hit_w0 || hit_w1;
            end
            if (acc_ph && !ack_r && !pwrite_i) begin
                if (sel_mem_r) begin
                    prdata_o <= {16'h0000, mem_q};
                end else if (hit_st) begin
                    prdata_o <= stat;
                end else begin
                    prdata_o <= 32'h0000_0000;
                end
            end
        end
    end

    // --------------------------------------------------------------
    // Setup word storage
    // --------------------------------------------------------------
    oscfg_setup_regs u_regs (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .ce_i    (ce_i),
        .we_i    (pready_o && pwrite_i && (hit_w0 || hit_w1)),
        .waddr_i (hit_w1),
        .wstrb_i (pstrb_i[1:0]),
        .wdata_i (pwdata_i[15:0]),
        .re_i    (setup_ph),
        .raddr_i (hit_w1),
        .rdata_o (mem_q),
        .word0_o (word0),
        .word1_o (word1)
    );

    // --------------------------------------------------------------
    // Field extraction and checks
    // --------------------------------------------------------------
    assign f_en    = oscfg_fld(word0, OSC_EN_LSB);
    assign f_scope = VER2_UNIT ? oscfg_fld(word0, OSC_SCOPE_LSB) : 4'h0;
    assign f_curve = VER2_UNIT ? oscfg_fld(word0, OSC_CURVE_LSB) : 4'h0;
    assign f_mode  = oscfg_fld(word1, OSC_MODE_LSB);
    assign f_rev   = oscfg_fld(word1, OSC_REV_LSB);
    assign f_det   = oscfg_fld(word1, OSC_DET_LSB);
    assign f_dir   = oscfg_fld(word1, OSC_DIR_LSB);

    // Bits 11:8 of word 0 take no part here
    assign pwr_bad = !oscfg_ok(f_en, OSC_MAX_BIN) || !oscfg_ok(f_scope, OSC_MAX_BIN)
                  || !oscfg_ok(f_curve, OSC_MAX_BIN);
    assign run_bad = !oscfg_ok(f_mode, OSC_MAX_TRI) || !oscfg_ok(f_rev, OSC_MAX_BIN)
                  || !oscfg_ok(f_det, OSC_MAX_TRI) || !oscfg_ok(f_dir, OSC_MAX_BIN);

    assign take_pwr = ce_i && power_up_i && !pwrup_done_r;
    assign take_run = ce_i && op_start_i;

    // --------------------------------------------------------------
    // Power-up latch of enable, scope and curve
    // --------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pwrup_done_r   <= 1'b0;
            search_en_o    <= 1'b0;
            limit_always_o <= 1'b0;
            s_curve_o      <= 1'b0;
            perr_r         <= 1'b0;
        end else if (take_pwr) begin
            pwrup_done_r   <= 1'b1;
            search_en_o    <= (f_en == 4'h1);
            limit_always_o <= (f_scope == 4'h1);
            s_curve_o      <= (f_curve == 4'h1);
            perr_r         <= pwr_bad;
        end
    end

    // --------------------------------------------------------------
    // Operation-start latch of search method fields
    // --------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mode_o     <= OSCFG_MODE0;
            reverse2_o <= 1'b0;
            detect_o   <= OSCFG_DET0;
            ccw_dir_o  <= 1'b0;
            serr_r     <= 1'b0;
        end else if (take_run) begin
            mode_o     <= oscfg_ok(f_mode, OSC_MAX_TRI) ? oscfg_mode_e'(f_mode[1:0])
                                                        : OSCFG_MODE0;
            reverse2_o <= (f_rev == 4'h1);
            detect_o   <= oscfg_ok(f_det, OSC_MAX_TRI) ? oscfg_det_e'(f_det[1:0])
                                                       : OSCFG_DET0;
            ccw_dir_o  <= (f_dir == 4'h1);
            serr_r     <= run_bad;
        end
    end

    assign cfg_err_o = perr_r || serr_r;

    // --------------------------------------------------------------
    // Limit mirror and scope
    // --------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            lim_r <= 4'h0;
        end else if (ce_i) begin
            lim_r <= {lim_ccw_i[1], lim_cw_i[1], lim_ccw_i[0], lim_cw_i[0]};
        end
    end

    assign out0_cw_limit_flag_o  = lim_r[0];
    assign out0_ccw_limit_flag_o = lim_r[1];
    assign out1_cw_limit_flag_o  = lim_r[2];
    assign out1_ccw_limit_flag_o = lim_r[3];
    assign limit_active_o        = limit_always_o || search_busy_i;

    // --------------------------------------------------------------
    // Resource takeover while search is enabled
    // --------------------------------------------------------------
    assign irq0_avail_o = !search_en_o;
    assign irq1_avail_o = !search_en_o;
    assign pwm0_avail_o = !search_en_o;
    assign hsc0_avail_o = 1'b1;
    assign hsc1_avail_o = 1'b1;
    assign irq_req_o    = search_en_o ? 2'b00 : irq_req_i;
    assign pwm0_o       = pwm0_i && !search_en_o;

    // Status word
    always_comb begin
        stat = 32'h0000_0000;
        stat[OSC_ST_EN]           = search_en_o;
        stat[OSC_ST_SCOPE]        = limit_always_o;
        stat[OSC_ST_CURVE]        = s_curve_o;
        stat[OSC_ST_MODE +: 2]    = mode_o;
        stat[OSC_ST_REV]          = reverse2_o;
        stat[OSC_ST_DET +: 2]     = detect_o;
        stat[OSC_ST_DIR]          = ccw_dir_o;
        stat[OSC_ST_PERR]         = perr_r;
        stat[OSC_ST_SERR]         = serr_r;
        stat[OSC_ST_PWRUP]        = pwrup_done_r;
        stat[OSC_ST_LIM +: 4]     = lim_r;
    end

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    a_enable_latch: assert property (take_pwr && word0[3:0] == 4'h1 |=> search_en_o)
        else $error("enable not latched");
    a_takeover_irq: assert property (search_en_o |-> irq_req_o == 2'b00 && !pwm0_o
        && hsc0_avail_o && hsc1_avail_o)
        else $error("resources not withheld");
    a_power_hold: assert property (ce_i && !take_pwr |=> $stable(search_en_o)
        && $stable(s_curve_o) && $stable(limit_always_o))
        else $error("power fields changed");
    a_start_hold: assert property (!take_run |=> $stable(mode_o) && $stable(detect_o)
        && $stable(reverse2_o) && $stable(ccw_dir_o))
        else $error("run fields changed");
    a_scope_apply: assert property (!search_busy_i && !limit_always_o |-> !limit_active_o)
        else $error("limit scope wrong");
    a_limit_mirror: assert property (ce_i |=>
        {out1_ccw_limit_flag_o, out1_cw_limit_flag_o,
         out0_ccw_limit_flag_o, out0_cw_limit_flag_o}
        == $past({lim_ccw_i[1], lim_cw_i[1], lim_ccw_i[0], lim_cw_i[0]}))
        else $error("limit flag stale");
    a_curve_latch: assert property (take_pwr && VER2_UNIT && word0[15:12] == 4'h1
        |=> s_curve_o)
        else $error("curve not latched");
    a_mode_latch: assert property (take_run && word1[3:0] == 4'h2 && word1[7:4] <= 4'h1
        && word1[11:8] <= 4'h2 && word1[15:12] <= 4'h1
        |=> mode_o == OSCFG_MODE2 && !serr_r)
        else $error("mode not latched");
    a_rev_latch: assert property (take_run && word1[7:4] == 4'h1 |=> reverse2_o)
        else $error("reversal not latched");
    a_det_latch: assert property (take_run && word1[11:8] == 4'h1
        |=> detect_o == OSCFG_DET1)
        else $error("detect not latched");
    a_dir_latch: assert property (take_run && word1[15:12] == 4'h0 |=> !ccw_dir_o)
        else $error("direction not latched");
    a_bad_code: assert property (take_run && word1[3:0] > 4'h2 |=> cfg_err_o
        && mode_o == OSCFG_MODE0)
        else $error("bad code not flagged");

    c_power_enable: cover property (take_pwr && word0[3:0] == 4'h1 ##1 search_en_o);
    c_start_mode2:  cover property (take_run ##1 mode_o == OSCFG_MODE2);
    c_apb_write:    cover property (pready_o && pwrite_i && !pslverr_o);
    c_setup_error:  cover property (take_run ##1 cfg_err_o);

endmodule
